// ==== hw/tdm_global_params.svh ====
// Offsets, field positions, reset values for the timeslot global registers.
// Assumes byte addressing on a 32-bit register bus, one word per register.
`ifndef TDM_GLOBAL_PARAMS_SVH
`define TDM_GLOBAL_PARAMS_SVH

`define OFF_BYTE_ORDER 12'h10c
`define OFF_TX_MAP 12'h110
`define OFF_RX_MAP 12'h114
`define OFF_XFER_CTRL 12'h180
`define OFF_TX_TIMING 12'h184
`define OFF_RX_TIMING 12'h188
`define OFF_TX_CFG 12'h190
`define OFF_RX_CFG 12'h194
`define OFF_IRQ_STATUS 12'h1a0
`define OFF_IRQ_MASK 12'h1a4

`define ADDR_W 12
`define LEVEL_LSB 0
`define CEIL_LSB 4
`define DELAY_LSB 0
`define FRAME_SEL_LSB 12
`define SF_SEL_LSB 14

`define DELAY_RST 7'h7f
`define LEVEL_RST 3'h0
`define CEIL_RST 3'h0
`define SEL_RST 2'h0
`define NUM_IRQ 4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hw/tdm_global_pkg.sv ====
// Types shared by the timeslot global register block.
// Assumes the params header carries every number.
package tdm_global_pkg;

   typedef enum logic [1:0] {
      SEL_ACK,
      SEL_DELAY,
      SEL_EITHER,
      SEL_BOTH
   } irq_sel_t;

   typedef enum logic {
      EV_IDLE,
      EV_WAIT
   } ev_state_t;

endpackage

// ==== hw/tdm_global_regs.sv ====
// Global configuration, status and event interrupt logic of the timeslot
// memory unit and its transfer control unit, reached over AXI4-Lite.
// Assumes the transfer logic runs on core_clk and drives its status and
// event strobes synchronously; only the dma enable level is taken as is.
`include "tdm_global_params.svh"
`timescale 1ns/10ps
`default_nettype none

module tdm_global_regs (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // AXI4-Lite write address
   input wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Transfer unit state
   input wire logic dma_enable,
   input wire logic [1:0] tx_map_select_state,
   input wire logic [1:0] rx_map_select_state,
   input wire logic [1:0] tx_config_set_state,
   input wire logic [1:0] rx_config_set_state,
   // Events, index 0 tx frame, 1 tx superframe, 2 rx frame, 3 rx superframe
   input wire logic timeslot_tick,
   input wire logic [`NUM_IRQ-1:0] event_pending,
   input wire logic [`NUM_IRQ-1:0] event_ack,
   // Configuration to the transfer logic
   output logic byte_order_select,
   output logic [2:0] transfer_urgency_level,
   output logic [2:0] urgency_ceiling,
   // Interrupt
   output logic irq
);

   logic byte_order_r;
   logic [2:0] level_r;
   logic [2:0] ceiling_r;
   logic [6:0] tx_delay_r;
   logic [6:0] rx_delay_r;
   logic [1:0] tx_fr_sel_r;
   logic [1:0] tx_sf_sel_r;
   logic [1:0] rx_fr_sel_r;
   logic [1:0] rx_sf_sel_r;
   logic [`NUM_IRQ-1:0] irq_status_r;
   logic [`NUM_IRQ-1:0] irq_mask_r;
   logic [`NUM_IRQ-1:0] fire;
   logic [2:0] ceiling_eff;

   // Bus slave registers
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [`ADDR_W-1:0] wr_addr_r;
   logic [31:0] wr_data_r;
   logic [3:0] wr_strb_r;
   logic do_wr;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] rd_word;
   logic we_order;
   logic we_xfer;
   logic we_tx_timing;
   logic we_rx_timing;
   logic we_status;
   logic we_mask;

   function automatic logic known_addr(input logic [`ADDR_W-1:0] a);
      case (a)
         `OFF_BYTE_ORDER, `OFF_TX_MAP, `OFF_RX_MAP, `OFF_XFER_CTRL,
         `OFF_TX_TIMING, `OFF_RX_TIMING, `OFF_TX_CFG, `OFF_RX_CFG,
         `OFF_IRQ_STATUS, `OFF_IRQ_MASK: known_addr = 1'b1;
         default: known_addr = 1'b0;
      endcase
   endfunction

   // Decides whether an event is due under a given source selection
   function automatic logic sel_due(input logic [1:0] sel, input logic ack, input logic expired);
      case (tdm_global_pkg::irq_sel_t'(sel))
         tdm_global_pkg::SEL_ACK: sel_due = ack;
         tdm_global_pkg::SEL_DELAY: sel_due = expired;
         tdm_global_pkg::SEL_EITHER: sel_due = ack | expired;
         tdm_global_pkg::SEL_BOTH: sel_due = ack & expired;
         default: sel_due = 1'b0;
      endcase
   endfunction

   assign do_wr = !awready_r && !wready_r && !bvalid_r;
   assign wr_hit = do_wr && known_addr(wr_addr_r);
   assign rd_hit = known_addr(s_axi_araddr);

   // One decoded strobe per writable register, so each field block tests a single name
   assign we_order = wr_hit && wr_addr_r == `OFF_BYTE_ORDER;
   assign we_xfer = wr_hit && wr_addr_r == `OFF_XFER_CTRL;
   assign we_tx_timing = wr_hit && wr_addr_r == `OFF_TX_TIMING;
   assign we_rx_timing = wr_hit && wr_addr_r == `OFF_RX_TIMING;
   assign we_status = wr_hit && wr_addr_r == `OFF_IRQ_STATUS;
   assign we_mask = wr_hit && wr_addr_r == `OFF_IRQ_MASK;

   // Address and data are taken independently; the write happens once both are held
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         awready_r <= 1'b1;
         wr_addr_r <= '0;
      end else if (s_axi_awvalid && awready_r) begin
         awready_r <= 1'b0;
         wr_addr_r <= s_axi_awaddr;
      end else if (bvalid_r && s_axi_bready) begin
         awready_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wready_r <= 1'b1;
         wr_data_r <= '0;
         wr_strb_r <= '0;
      end else if (s_axi_wvalid && wready_r) begin
         wready_r <= 1'b0;
         wr_data_r <= s_axi_wdata;
         wr_strb_r <= s_axi_wstrb;
      end else if (bvalid_r && s_axi_bready) begin
         wready_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bvalid_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // State inputs are shown live; they have no write path, so writes to them are ignored
   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         `OFF_BYTE_ORDER: rd_word[0] = byte_order_r;
         `OFF_TX_MAP: rd_word[1:0] = tx_map_select_state;
         `OFF_RX_MAP: rd_word[1:0] = rx_map_select_state;
         `OFF_XFER_CTRL: begin
            rd_word[`LEVEL_LSB +: 3] = level_r;
            rd_word[`CEIL_LSB +: 3] = ceiling_r;
         end
         `OFF_TX_TIMING: begin
            rd_word[`DELAY_LSB +: 7] = tx_delay_r;
            rd_word[`FRAME_SEL_LSB +: 2] = tx_fr_sel_r;
            rd_word[`SF_SEL_LSB +: 2] = tx_sf_sel_r;
         end
         `OFF_RX_TIMING: begin
            rd_word[`DELAY_LSB +: 7] = rx_delay_r;
            rd_word[`FRAME_SEL_LSB +: 2] = rx_fr_sel_r;
            rd_word[`SF_SEL_LSB +: 2] = rx_sf_sel_r;
         end
         `OFF_TX_CFG: rd_word[1:0] = tx_config_set_state;
         `OFF_RX_CFG: rd_word[1:0] = rx_config_set_state;
         `OFF_IRQ_STATUS: rd_word[`NUM_IRQ-1:0] = irq_status_r;
         `OFF_IRQ_MASK: rd_word[`NUM_IRQ-1:0] = irq_mask_r;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= `RESP_OKAY;
      end else if (s_axi_arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // Configuration is frozen while the transfer unit runs so it never sees a half-changed setup
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         byte_order_r <= 1'b0;
      end else if (we_order && wr_strb_r[0] && !dma_enable) begin
         byte_order_r <= wr_data_r[0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         level_r <= `LEVEL_RST;
         ceiling_r <= `CEIL_RST;
      end else if (we_xfer && wr_strb_r[0] && !dma_enable) begin
         level_r <= wr_data_r[`LEVEL_LSB +: 3];
         ceiling_r <= wr_data_r[`CEIL_LSB +: 3];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_delay_r <= `DELAY_RST;
         tx_fr_sel_r <= `SEL_RST;
         tx_sf_sel_r <= `SEL_RST;
      end else if (we_tx_timing && !dma_enable) begin
         if (wr_strb_r[0]) begin
            tx_delay_r <= wr_data_r[`DELAY_LSB +: 7];
         end
         if (wr_strb_r[1]) begin
            tx_fr_sel_r <= wr_data_r[`FRAME_SEL_LSB +: 2];
            tx_sf_sel_r <= wr_data_r[`SF_SEL_LSB +: 2];
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_delay_r <= `DELAY_RST;
         rx_fr_sel_r <= `SEL_RST;
         rx_sf_sel_r <= `SEL_RST;
      end else if (we_rx_timing && !dma_enable) begin
         if (wr_strb_r[0]) begin
            rx_delay_r <= wr_data_r[`DELAY_LSB +: 7];
         end
         if (wr_strb_r[1]) begin
            rx_fr_sel_r <= wr_data_r[`FRAME_SEL_LSB +: 2];
            rx_sf_sel_r <= wr_data_r[`SF_SEL_LSB +: 2];
         end
      end
   end

   // Per-event tracker: counts delay+1 timeslots after pending, notes the acknowledge
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_IRQ; gi = gi + 1) begin : g_ev
         tdm_global_pkg::ev_state_t st_r;
         logic [6:0] cnt_r;
         logic ack_seen_r;
         logic expired_r;
         logic ack_now;
         logic exp_now;
         logic [6:0] dly;
         logic [1:0] sel;

         assign dly = (gi < 2) ? tx_delay_r : rx_delay_r;
         assign sel = (gi == 0) ? tx_fr_sel_r : (gi == 1) ? tx_sf_sel_r :
                      (gi == 2) ? rx_fr_sel_r : rx_sf_sel_r;
         assign ack_now = ack_seen_r | event_ack[gi];
         assign exp_now = expired_r | (timeslot_tick && cnt_r == 7'h00);
         // Combined mode waits for both conditions of the same pending event
         assign fire[gi] = (st_r == tdm_global_pkg::EV_WAIT) && sel_due(sel, ack_now, exp_now);

         // A pending pulse seen while waiting is dropped: one event per source in flight
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               st_r <= tdm_global_pkg::EV_IDLE;
               cnt_r <= 7'h00;
               ack_seen_r <= 1'b0;
               expired_r <= 1'b0;
            end else begin
               case (st_r)
                  tdm_global_pkg::EV_IDLE: begin
                     if (event_pending[gi]) begin
                        st_r <= tdm_global_pkg::EV_WAIT;
                        cnt_r <= dly;
                        ack_seen_r <= event_ack[gi];
                        expired_r <= 1'b0;
                     end
                  end
                  tdm_global_pkg::EV_WAIT: begin
                     if (fire[gi]) begin
                        st_r <= tdm_global_pkg::EV_IDLE;
                     end
                     ack_seen_r <= ack_now;
                     expired_r <= exp_now;
                     if (timeslot_tick && cnt_r != 7'h00) begin
                        cnt_r <= cnt_r - 7'h01;
                     end
                  end
                  default: st_r <= tdm_global_pkg::EV_IDLE;
               endcase
            end
         end
      end
   endgenerate

   // Set wins over a write-one clear landing in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_status_r <= '0;
      end else begin
         if (we_status && wr_strb_r[0]) begin
            irq_status_r <= (irq_status_r & ~wr_data_r[`NUM_IRQ-1:0]) | fire;
         end else begin
            irq_status_r <= irq_status_r | fire;
         end
      end
   end

   // A mask bit high lets the matching status bit reach irq
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_mask_r <= '0;
      end else if (we_mask && wr_strb_r[0]) begin
         irq_mask_r <= wr_data_r[`NUM_IRQ-1:0];
      end
   end

   // A ceiling numerically above the level would mean less urgent than the base; clamp it
   assign ceiling_eff = (ceiling_r > level_r) ? level_r : ceiling_r;

   // Registered so the pins never show a half-settled decode or a glitch on irq
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         byte_order_select <= 1'b0;
         transfer_urgency_level <= `LEVEL_RST;
         urgency_ceiling <= `CEIL_RST;
         irq <= 1'b0;
      end else begin
         byte_order_select <= byte_order_r;
         transfer_urgency_level <= level_r;
         urgency_ceiling <= ceiling_eff;
         irq <= |(irq_status_r & irq_mask_r);
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

endmodule

`default_nettype wire

// ==== tb/tdm_global_regs_properties.sv ====
// Bus and configuration output checks for the global register block.
// Assumes it sees only the block's ports, attached by the bind below.
`include "tdm_global_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tdm_global_regs_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Configuration
   input wire logic dma_enable,
   input wire logic byte_order_select,
   input wire logic [2:0] transfer_urgency_level,
   input wire logic [2:0] urgency_ceiling
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   write_resp_due_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   write_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   read_resp_due_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response late");
   read_resp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   unmapped_read_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h1fc |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read answered");
   map_state_read_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h110 |=> s_axi_rdata[31:2] == 30'h0 && s_axi_rdata[1:0] != 2'h3)
      else $error("bitmap state read bad");
   ceiling_clamp_a: assert property (urgency_ceiling <= transfer_urgency_level)
      else $error("ceiling above level");
   order_lock_a: assert property ($past(dma_enable, 2) |-> $stable(byte_order_select))
      else $error("byte order changed while running");
   level_lock_a: assert property ($past(dma_enable, 2) |-> $stable(transfer_urgency_level))
      else $error("level changed while running");
endmodule
bind tdm_global_regs tdm_global_regs_properties chk_u (.*);
`default_nettype wire

// ==== tb/tdm_global_regs_tb.sv ====
// Self-checking bench of the global register block with a transfer logic model.
// Assumes the tick period of the model is four cycles.
`include "tdm_global_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tdm_global_regs_tb;
   logic core_clk = 1'h0, rst = 1'h1, dma_enable = 1'h0, ev_go = 1'h0, early, slow = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, byte_order_select, timeslot_tick;
   logic [`ADDR_W-1:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hac91;
   logic [3:0] s_axi_wstrb = 4'hf, event_pending, event_ack;
   logic [1:0] s_axi_bresp, s_axi_rresp, ev_src = 2'h0;
   logic [1:0] tx_map_select_state = 2'h0, rx_map_select_state = 2'h0, tx_config_set_state = 2'h0, rx_config_set_state = 2'h0;
   logic [2:0] transfer_urgency_level, urgency_ceiling;
   logic [7:0] ack_lag = 8'h0;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [11:0] ra[5] = '{12'h184, 12'h188, 12'h10c, 12'h180, 12'h1fc};
   logic [33:0] re[5] = '{34'h7f, 34'h7f, 34'h0, 34'h0, 34'h200000000};
   int n_fail = 0, n_tests = 0, cnt;
   always #25 core_clk = ~core_clk;
   tdm_global_regs dut_u (.*);
   tdm_xfer_model #(.TICK_DIV(4)) model_u (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Answers are matched in arrival order against the notes left by the driver
   always @(posedge core_clk) begin
      if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(bq.pop_front()));
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      bq.push_back(er);
      slow = ~slow;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      // Every other transfer raises ready only once the answer stands, so a held answer is exercised
      s_axi_bready <= !slow;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'h1;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      rq.push_back(e);
      slow = ~slow;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= !slow;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic fire(input int src, input logic [7:0] lag);
      ev_src <= 2'(src);
      ack_lag <= lag;
      ev_go <= 1'h1;
      @(posedge core_clk);
      ev_go <= 1'h0;
      @(posedge core_clk);
   endtask
   initial begin
      #2_000_000;
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'h0;
      @(posedge core_clk);
      for (int i = 0; i < 5; i++) rd(ra[i], re[i]);
      wr(12'h1fc, 32'hffffffff, 2'h2);
      repeat (4) begin
         seed = lfsr(seed);
         tx_map_select_state <= seed[1:0] % 2'h3;
         rx_map_select_state <= seed[3:2] % 2'h3;
         tx_config_set_state <= seed[5:4] % 2'h3;
         rx_config_set_state <= seed[7:6] % 2'h3;
         wr(12'h110, 32'hffffffff, 2'h0);
         rd(12'h110, 34'(tx_map_select_state));
         rd(12'h114, 34'(rx_map_select_state));
         rd(12'h190, 34'(tx_config_set_state));
         rd(12'h194, 34'(rx_config_set_state));
         wr(12'h180, seed, 2'h0);
         rd(12'h180, 34'(seed & 32'h77));
         check(34'(urgency_ceiling), 34'(seed[6:4] > seed[2:0] ? seed[2:0] : seed[6:4]));
         check(34'(transfer_urgency_level), 34'(seed[2:0]));
      end
      wr(12'h10c, 32'hffffffff, 2'h0);
      check(34'(byte_order_select), 34'h1);
      dma_enable <= 1'h1;
      wr(12'h10c, 32'h0, 2'h0);
      wr(12'h180, ~seed, 2'h0);
      wr(12'h184, 32'h0, 2'h0);
      rd(12'h10c, 34'h1);
      rd(12'h180, 34'(seed & 32'h77));
      rd(12'h184, 34'h7f);
      dma_enable <= 1'h0;
      wr(12'h184, 32'hffffffff, 2'h0);
      rd(12'h184, 34'hf07f);
      wr(12'h188, 32'hffffffff, 2'h0);
      rd(12'h188, 34'hf07f);
      wr(12'h1a4, 32'hf, 2'h0);
      // Acknowledge comes long after the first tick, so each selection shows its own timing
      for (int s = 0; s < 4; s++) begin
         for (int m = 0; m < 4; m++) begin
            wr(s < 2 ? 12'h184 : 12'h188, 32'(m) << (s[0] ? 14 : 12), 2'h0);
            fire(s, 8'h14);
            early = 1'h0;
            repeat (16) @(posedge core_clk) early |= irq;
            check(34'(early), 34'(m == 1 || m == 2));
            repeat (10) @(posedge core_clk);
            check(34'(irq), 34'h1);
            wr(12'h1a0, 32'hf, 2'h0);
            repeat (2) @(posedge core_clk);
            check(34'(irq), 34'h0);
         end
      end
      for (int s = 0; s < 4; s += 2) begin
         wr(s ? 12'h188 : 12'h184, 32'h1000 | (s ? 32'h0 : 32'h5), 2'h0);
         fire(s, 8'h0);
         cnt = 0;
         do begin
            @(posedge core_clk);
            cnt += int'(timeslot_tick);
         end while (irq !== 1'h1 && cnt < 20);
         check(34'(cnt), s ? 34'h1 : 34'h6);
         wr(12'h1a0, 32'hf, 2'h0);
      end
      wr(12'h1a4, 32'he, 2'h0);
      wr(12'h184, 32'h0, 2'h0);
      fire(0, 8'h2);
      repeat (6) @(posedge core_clk);
      check(34'(irq), 34'h0);
      rd(12'h1a0, 34'h1);
      wr(12'h1a0, 32'h1, 2'h0);
      rd(12'h1a0, 34'h0);
      finish_test();
   end
endmodule
`default_nettype wire

// ==== tb/tdm_xfer_model.sv ====
// Model of the transfer logic beside the register block: timeslot tick and event strobes.
// Assumes one event outstanding at a time; a lag of zero means the transfer is never acknowledged.
`timescale 1ns/10ps
`default_nettype none
module tdm_xfer_model #(
   parameter int TICK_DIV = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Commands from the bench
   input wire logic ev_go,
   input wire logic [1:0] ev_src,
   input wire logic [7:0] ack_lag,
   // Strobes to the register block
   output logic timeslot_tick,
   output logic [3:0] event_pending,
   output logic [3:0] event_ack
);
   logic [7:0] div_r;
   logic [7:0] lag_r;
   logic [1:0] src_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_r <= 8'h0;
         timeslot_tick <= 1'h0;
      end else begin
         div_r <= (div_r == 8'(TICK_DIV - 1)) ? 8'h0 : div_r + 8'h1;
         timeslot_tick <= (div_r == 8'h0);
      end
   end
   // Slow acknowledge lets the bench tell delay expiry apart from acknowledge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         event_pending <= 4'h0;
         event_ack <= 4'h0;
         lag_r <= 8'h0;
         src_r <= 2'h0;
      end else begin
         event_pending <= ev_go ? 4'h1 << ev_src : 4'h0;
         event_ack <= (lag_r == 8'h1) ? 4'h1 << src_r : 4'h0;
         lag_r <= ev_go ? ack_lag : (lag_r != 8'h0 ? lag_r - 8'h1 : 8'h0);
         src_r <= ev_go ? ev_src : src_r;
      end
   end
endmodule
`default_nettype wire
